// ==== iex_device.sv ====
`timescale 1ns/10ps
`default_nettype none
module iex_device (
  input wire logic hclk,
  input wire logic hresetn,
  iex_link_if.dev link,
  input wire logic addr_select_hi,
  input wire logic addr_select_mid,
  input wire logic addr_select_lo,
  input wire logic [7:0] port_pins_in,
  output logic [7:0] port_pins_out,
  output logic [7:0] port_pins_oe,
  output logic attn_n_oe
);
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic [7:0] pin_s1, pin_sync;
  logic [2:0] sel_s1, sel_sync;
  iex_pkg::iex_dev_state_e st;
  iex_pkg::iex_phase_e phase;
  logic [3:0] cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic rw;
  logic sda_oe;
  logic [7:0] register_pointer;
  logic [7:0] input_invert;
  logic [7:0] pin_direction;
  logic [7:0] int_ref;
  logic ref_valid;
  logic [1:0] settle;
  logic rise, fall, start_ev, stop_ev;
  logic byte_done, addr_hit, tx_load;

  function automatic logic [7:0] read_sel(input logic [1:0] sel,
      input logic [7:0] lvl, input logic [7:0] inv,
      input logic [7:0] drv, input logic [7:0] dir);
    logic [7:0] v;
    v = 8'h00;
    unique case (sel)
      iex_pkg::PTR_INPUT: v = lvl ^ inv;
      iex_pkg::PTR_OUTPUT: v = drv;
      iex_pkg::PTR_INVERT: v = inv;
      iex_pkg::PTR_DIR: v = dir;
    endcase
    return v;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= link.scl;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= 8'h00;
      pin_sync <= 8'h00;
      sel_s1 <= 3'h0;
      sel_sync <= 3'h0;
    end else begin
      pin_s1 <= port_pins_in;
      pin_sync <= pin_s1;
      sel_s1 <= {addr_select_hi, addr_select_mid, addr_select_lo};
      sel_sync <= sel_s1;
    end
  end

  always_comb begin
    rise = scl_s2 & ~scl_s3;
    fall = ~scl_s2 & scl_s3;
    start_ev = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    stop_ev = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
    byte_done = (st == iex_pkg::DS_RX) && fall && (cnt == iex_pkg::BYTE_BITS);
    addr_hit = (rx_shift[7:1] == {iex_pkg::ADDR_FIXED, sel_sync});
    tx_load = rise && (((st == iex_pkg::DS_RX_ACK) && rw)
      || ((st == iex_pkg::DS_TX_ACK) && !sda_s2));
    // reference usable once the pin synchroniser has filled
    ref_valid = &settle;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= iex_pkg::DS_IDLE;
      phase <= iex_pkg::PH_ADDR;
      cnt <= 4'h0;
      rw <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_ev) begin
      st <= iex_pkg::DS_RX;
      phase <= iex_pkg::PH_ADDR;
      cnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_ev) begin
      st <= iex_pkg::DS_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (st)
        iex_pkg::DS_IDLE: begin
          sda_oe <= 1'b0;
        end
        iex_pkg::DS_RX: begin
          if (rise) begin
            cnt <= cnt + 4'h1;
          end
          if (byte_done) begin
            cnt <= 4'h0;
            if (phase == iex_pkg::PH_ADDR) begin
              if (addr_hit) begin
                rw <= rx_shift[0];
                sda_oe <= 1'b1;
                st <= iex_pkg::DS_RX_ACK;
                phase <= iex_pkg::PH_CMD;
              end else begin
                st <= iex_pkg::DS_IDLE;
              end
            end else begin
              sda_oe <= 1'b1;
              st <= iex_pkg::DS_RX_ACK;
              phase <= iex_pkg::PH_DATA;
            end
          end
        end
        iex_pkg::DS_RX_ACK: begin
          if (fall) begin
            if (rw) begin
              sda_oe <= ~tx_shift[7];
              cnt <= 4'h1;
              st <= iex_pkg::DS_TX;
            end else begin
              sda_oe <= 1'b0;
              cnt <= 4'h0;
              st <= iex_pkg::DS_RX;
            end
          end
        end
        iex_pkg::DS_TX: begin
          if (fall) begin
            if (cnt == iex_pkg::BYTE_BITS) begin
              sda_oe <= 1'b0;
              st <= iex_pkg::DS_TX_ACK;
            end else begin
              sda_oe <= ~tx_shift[6];
              cnt <= cnt + 4'h1;
            end
          end
        end
        iex_pkg::DS_TX_ACK: begin
          // nack from master ends the read
          if (rise && sda_s2) begin
            st <= iex_pkg::DS_IDLE;
          end else if (fall) begin
            sda_oe <= ~tx_shift[7];
            cnt <= 4'h1;
            st <= iex_pkg::DS_TX;
          end
        end
        default: begin
          st <= iex_pkg::DS_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_shift <= 8'h00;
    end else if ((st == iex_pkg::DS_RX) && rise) begin
      rx_shift <= {rx_shift[6:0], sda_s2};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_shift <= 8'h00;
    end else if (tx_load) begin
      tx_shift <= read_sel(register_pointer[1:0], pin_sync, input_invert,
        port_pins_out, pin_direction);
    end else if ((st == iex_pkg::DS_TX) && fall) begin
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      register_pointer <= iex_pkg::RST_PTR;
    end else if (byte_done && (phase == iex_pkg::PH_CMD)) begin
      register_pointer <= rx_shift;
    end
  end

  // data bytes go to selected register, except that writes to the input register are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_pins_out <= iex_pkg::RST_OUT;
      input_invert <= iex_pkg::RST_INV;
      pin_direction <= iex_pkg::RST_DIR;
      port_pins_oe <= ~iex_pkg::RST_DIR;
    end else if (byte_done && (phase == iex_pkg::PH_DATA)) begin
      unique case (register_pointer[1:0])
        iex_pkg::PTR_INPUT: begin
        end
        iex_pkg::PTR_OUTPUT: port_pins_out <= rx_shift;
        iex_pkg::PTR_INVERT: input_invert <= rx_shift;
        // one is input, zero is output
        iex_pkg::PTR_DIR: begin
          pin_direction <= rx_shift;
          port_pins_oe <= ~rx_shift;
        end
      endcase
    end
  end

  // reference caught after reset and at read ack while the input register is selected
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle <= 2'h0;
      int_ref <= 8'h00;
    end else begin
      // keep loading until synced pins show the real levels
      if (!ref_valid) begin
        settle <= settle + 2'h1;
      end
      if (!ref_valid
          || (tx_load && (register_pointer[1:0] == iex_pkg::PTR_INPUT))) begin
        int_ref <= pin_sync;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      attn_n_oe <= 1'b0;
    end else begin
      attn_n_oe <= ref_valid && |((pin_sync ^ int_ref) & pin_direction);
    end
  end

  assign link.sda_oe_d = sda_oe;
endmodule
`default_nettype wire

// ==== iex_pkg.sv ====
package iex_pkg;
  localparam logic [3:0] ADDR_FIXED = 4'h4;
  localparam logic [1:0] PTR_INPUT = 2'h0;
  localparam logic [1:0] PTR_OUTPUT = 2'h1;
  localparam logic [1:0] PTR_INVERT = 2'h2;
  localparam logic [1:0] PTR_DIR = 2'h3;
  localparam logic [7:0] RST_OUT = 8'hff;
  localparam logic [7:0] RST_INV = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_PTR = 8'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [7:0] HREG_CMD = 8'h00;
  localparam logic [7:0] HREG_STATUS = 8'h04;
  localparam int CMD_READ = 8;
  localparam int CMD_STOP = 9;
  localparam int CMD_START = 10;
  localparam int CMD_NACK = 11;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ACK = 1;
  localparam int STAT_RX_LSB = 8;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QUARTER_CYC = SCL_PERIOD_NS / (CLK_PERIOD_NS * 4);
  localparam logic [7:0] QUARTER_LAST = 8'(QUARTER_CYC - 1);
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_RX = 3'h1,
    DS_RX_ACK = 3'h2,
    DS_TX = 3'h3,
    DS_TX_ACK = 3'h4
  } iex_dev_state_e;
  typedef enum logic [1:0] {
    PH_ADDR = 2'h0,
    PH_CMD = 2'h1,
    PH_DATA = 2'h2
  } iex_phase_e;
  typedef enum logic [1:0] {
    HS_IDLE = 2'h0,
    HS_START = 2'h1,
    HS_BIT = 2'h2,
    HS_STOP = 2'h3
  } iex_host_state_e;
endpackage

// ==== iex_link_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface iex_link_if;
  logic scl_oe_h;
  logic sda_oe_h;
  logic sda_oe_d;
  wire scl;
  wire sda;
  // open-drain wires with pull-ups
  assign scl = ~scl_oe_h;
  assign sda = ~(sda_oe_h | sda_oe_d);
  modport dev (input scl, input sda, output sda_oe_d);
  modport host (input scl, input sda, output scl_oe_h, output sda_oe_h);
endinterface
`default_nettype wire

// ==== iex_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module iex_host (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  iex_link_if.host link
);
  iex_pkg::iex_host_state_e hst;
  logic [7:0] qcnt;
  logic tick;
  logic [1:0] ph;
  logic [3:0] bitn;
  logic [11:0] cmd;
  logic busy;
  logic ack_seen;
  logic [7:0] rx_byte;
  logic scl_oe, sda_oe;
  logic wr_pend;
  logic [7:0] addr_q;
  logic launch;
  logic [31:0] status;
  localparam int STAT_BUSY_IDX = iex_pkg::STAT_BUSY;
  localparam int STAT_ACK_IDX = iex_pkg::STAT_ACK;

  always_comb begin
    status = 32'h0;
    status[STAT_BUSY_IDX] = busy;
    status[STAT_ACK_IDX] = ack_seen;
    status[iex_pkg::STAT_RX_LSB +: 8] = rx_byte;
    launch = wr_pend && (addr_q == iex_pkg::HREG_CMD) && !busy;
    tick = (qcnt == iex_pkg::QUARTER_LAST);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
      wr_pend <= 1'b0;
      addr_q <= 8'h00;
    end else begin
      wr_pend <= 1'b0;
      if (hready && hsel && htrans[1]) begin
        wr_pend <= hwrite;
        addr_q <= haddr[7:0];
        if (!hwrite) begin
          if (haddr[7:0] == iex_pkg::HREG_CMD) begin
            hrdata <= {20'h0, cmd};
          end else if (haddr[7:0] == iex_pkg::HREG_STATUS) begin
            hrdata <= status;
          end else begin
            hrdata <= 32'h0;
          end
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd <= 12'h000;
    end else if (launch) begin
      cmd <= hwdata[11:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qcnt <= 8'h00;
    end else if (launch || tick) begin
      qcnt <= 8'h00;
    end else if (hst != iex_pkg::HS_IDLE) begin
      qcnt <= qcnt + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hst <= iex_pkg::HS_IDLE;
      ph <= 2'h0;
      bitn <= 4'h0;
      busy <= 1'b0;
      ack_seen <= 1'b0;
      rx_byte <= 8'h00;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (launch) begin
      busy <= 1'b1;
      ph <= 2'h0;
      bitn <= 4'h0;
      if (hwdata[iex_pkg::CMD_STOP]) begin
        hst <= iex_pkg::HS_STOP;
      end else if (hwdata[iex_pkg::CMD_START]) begin
        hst <= iex_pkg::HS_START;
      end else begin
        hst <= iex_pkg::HS_BIT;
      end
    end else if (tick) begin
      ph <= ph + 2'h1;
      unique case (hst)
        iex_pkg::HS_IDLE: begin
        end
        iex_pkg::HS_START: begin
          unique case (ph)
            2'h0: begin
              sda_oe <= 1'b0;
              scl_oe <= 1'b1;
            end
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b1;
            2'h3: begin
              scl_oe <= 1'b1;
              hst <= iex_pkg::HS_BIT;
            end
          endcase
        end
        iex_pkg::HS_BIT: begin
          unique case (ph)
            2'h0: begin
              if (bitn != iex_pkg::ACK_BIT) begin
                sda_oe <= !cmd[iex_pkg::CMD_READ]
                  && !cmd[3'(4'h7 - bitn)];
              end else begin
                sda_oe <= cmd[iex_pkg::CMD_READ] && !cmd[iex_pkg::CMD_NACK];
              end
            end
            2'h1: scl_oe <= 1'b0;
            2'h2: begin
              if (bitn != iex_pkg::ACK_BIT) begin
                rx_byte <= {rx_byte[6:0], link.sda};
              end else if (!cmd[iex_pkg::CMD_READ]) begin
                ack_seen <= !link.sda;
              end
            end
            2'h3: begin
              scl_oe <= 1'b1;
              if (bitn == iex_pkg::ACK_BIT) begin
                busy <= 1'b0;
                hst <= iex_pkg::HS_IDLE;
              end else begin
                bitn <= bitn + 4'h1;
              end
            end
          endcase
        end
        iex_pkg::HS_STOP: begin
          unique case (ph)
            2'h0: begin
              scl_oe <= 1'b1;
              sda_oe <= 1'b1;
            end
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b0;
            2'h3: begin
              busy <= 1'b0;
              hst <= iex_pkg::HS_IDLE;
            end
          endcase
        end
      endcase
    end
  end

  assign link.scl_oe_h = scl_oe;
  assign link.sda_oe_h = sda_oe;
endmodule
`default_nettype wire

// ==== iex_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module iex_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic scl,
  input wire logic sda_oe_d,
  input wire logic [7:0] port_pins_in,
  input wire logic [7:0] port_pins_out,
  input wire logic [7:0] port_pins_oe,
  input wire logic attn_n_oe
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // a few cycles after scl went low
  sequence s_after_fall;
    !scl && $past(scl, 8);
  endsequence
  sequence s_scl_high;
    scl && $past(scl);
  endsequence
  sequence s_all_out;
    (port_pins_oe == 8'hff) [*4];
  endsequence
  property p_sda_hold;
    s_scl_high |-> $stable(sda_oe_d);
  endproperty
  a_sda_hold: assert property (p_sda_hold)
    else $error("device sda changed while scl high");
  property p_sda_launch;
    $rose(sda_oe_d) |-> s_after_fall;
  endproperty
  a_sda_launch: assert property (p_sda_launch)
    else $error("device sda pulled away from scl fall");
  property p_sda_release;
    $fell(sda_oe_d) |-> !scl;
  endproperty
  a_sda_release: assert property (p_sda_release)
    else $error("device sda released while scl high");
  property p_out_change;
    $changed(port_pins_out) |-> s_after_fall;
  endproperty
  a_out_change: assert property (p_out_change)
    else $error("output register changed off a byte end");
  property p_oe_change;
    $changed(port_pins_oe) |-> s_after_fall;
  endproperty
  a_oe_change: assert property (p_oe_change)
    else $error("pin direction changed off a byte end");
  property p_attn_out;
    s_all_out |-> !attn_n_oe;
  endproperty
  a_attn_out: assert property (p_attn_out)
    else $error("attention raised with all pins outputs");
  property p_attn_input;
    $rose(attn_n_oe) |-> ($past(port_pins_oe) != 8'hff);
  endproperty
  a_attn_input: assert property (p_attn_input)
    else $error("attention raised with no input pin");
  property p_attn_cause;
    $rose(attn_n_oe) |-> ($past(port_pins_in, 2) != $past(port_pins_in, 5))
      || ($past(port_pins_oe) != $past(port_pins_oe, 3));
  endproperty
  a_attn_cause: assert property (p_attn_cause)
    else $error("attention raised without a pin change");
  property p_scl_pulse;
    $rose(scl) |-> scl [*8];
  endproperty
  a_scl_pulse: assert property (p_scl_pulse)
    else $error("scl high pulse too short");
endmodule
`default_nettype wire

// ==== i2c_eight_bit_io_expander_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module i2c_eight_bit_io_expander_tb;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [2:0] sel = 3'h5;
  logic [7:0] ext = 8'h3c;
  logic [7:0] pins_out;
  logic [7:0] pins_oe;
  logic [7:0] pins_in;
  logic attn_n_oe;
  int error_cnt = 0;
  int checked = 0;
  iex_link_if link();
  always #12.5 hclk = ~hclk;
  // driven pins follow the output register, others the outside level
  assign pins_in = (pins_oe & pins_out) | (~pins_oe & ext);
  iex_device u_iex_device (.hclk(hclk), .hresetn(hresetn), .link(link),
    .addr_select_hi(sel[2]), .addr_select_mid(sel[1]),
    .addr_select_lo(sel[0]), .port_pins_in(pins_in),
    .port_pins_out(pins_out), .port_pins_oe(pins_oe),
    .attn_n_oe(attn_n_oe));
  iex_host u_iex_host (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .link(link));
  iex_assertions u_iex_assertions (.hclk(hclk), .hresetn(hresetn),
    .scl(link.scl), .sda_oe_d(link.sda_oe_d), .port_pins_in(pins_in),
    .port_pins_out(pins_out), .port_pins_oe(pins_oe),
    .attn_n_oe(attn_n_oe));
  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check_byte(input string name, input logic [7:0] exp,
    input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic check_bit(input string name, input logic exp,
    input logic got);
    check_byte(name, {7'h0, exp}, {7'h0, got});
  endtask
  task automatic hang(input string what);
    error_cnt++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    wrap_up();
  endtask
  // hready and read data taken at the rising edge ending the phase
  task automatic bus_wait(output logic [31:0] rd);
    int n;
    logic ok;
    n = 0;
    ok = 1'b0;
    while (!ok) begin
      @(posedge hclk);
      ok = (hreadyout === 1'b1);
      rd = hrdata;
      n++;
      if (n > 100) hang("hready");
    end
  endtask
  task automatic ahb(input logic [31:0] a, input logic w,
    input logic [31:0] wd, output logic [31:0] rd);
    logic [31:0] x;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    bus_wait(x);
    htrans <= 2'h0;
    hwdata <= wd;
    bus_wait(rd);
  endtask
  task automatic run(input logic [31:0] c, output logic [31:0] st);
    int n;
    n = 0;
    ahb({24'h0, iex_pkg::HREG_CMD}, 1'b1, c, st);
    st[iex_pkg::STAT_BUSY] = 1'b1;
    while (st[iex_pkg::STAT_BUSY] !== 1'b0) begin
      ahb({24'h0, iex_pkg::HREG_STATUS}, 1'b0, 32'h0, st);
      n++;
      if (n > 3000) hang("busy");
    end
  endtask
  task automatic send(input logic s, input logic [7:0] b, input logic ack);
    logic [31:0] c;
    logic [31:0] st;
    c = {24'h0, b};
    c[iex_pkg::CMD_START] = s;
    run(c, st);
    check_bit("ack", ack, st[iex_pkg::STAT_ACK]);
  endtask
  task automatic recv(input logic nack, input logic [7:0] exp);
    logic [31:0] c;
    logic [31:0] st;
    c = 32'h0;
    c[iex_pkg::CMD_READ] = 1'b1;
    c[iex_pkg::CMD_NACK] = nack;
    run(c, st);
    check_byte("rx", exp, st[15:8]);
  endtask
  task automatic stop;
    logic [31:0] c;
    logic [31:0] st;
    c = 32'h0;
    c[iex_pkg::CMD_STOP] = 1'b1;
    run(c, st);
  endtask
  task automatic attn_is(input logic [7:0] v, input logic e);
    @(posedge hclk);
    ext <= v;
    repeat (6) @(negedge hclk);
    check_bit("attn", e, attn_n_oe);
    @(posedge hclk);
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_byte("out", 8'hff, pins_out);
    check_byte("oe", 8'h00, pins_oe);
    send(1'b1, 8'h4a, 1'b1);
    send(1'b0, 8'h03, 1'b1);
    send(1'b0, 8'h00, 1'b1);
    check_byte("oe", 8'hff, pins_oe);
    send(1'b0, 8'h0f, 1'b1);
    stop();
    check_byte("oe", 8'hf0, pins_oe);
    send(1'b1, 8'h4a, 1'b1);
    send(1'b0, 8'h01, 1'b1);
    send(1'b0, 8'ha5, 1'b1);
    send(1'b1, 8'h4b, 1'b1);
    recv(1'b1, 8'ha5);
    stop();
    check_byte("out", 8'ha5, pins_out);
    check_bit("attn", 1'b0, attn_n_oe);
    send(1'b1, 8'h4a, 1'b1);
    send(1'b0, 8'hfe, 1'b1);
    send(1'b0, 8'h0f, 1'b1);
    stop();
    send(1'b1, 8'h4b, 1'b1);
    recv(1'b1, 8'h0f);
    stop();
    attn_is(8'h3d, 1'b1);
    attn_is(8'h3c, 1'b0);
    attn_is(8'h3d, 1'b1);
    send(1'b1, 8'h4a, 1'b1);
    send(1'b0, 8'h00, 1'b1);
    send(1'b0, 8'h00, 1'b1);
    send(1'b1, 8'h4b, 1'b1);
    recv(1'b0, 8'ha2);
    recv(1'b1, 8'ha2);
    stop();
    check_byte("out", 8'ha5, pins_out);
    check_byte("oe", 8'hf0, pins_oe);
    check_bit("attn", 1'b0, attn_n_oe);
    send(1'b1, 8'h4e, 1'b0);
    stop();
    check_byte("out", 8'ha5, pins_out);
    wrap_up();
  end
endmodule
`default_nettype wire
